// ### logic/pin_cfg_pkg.sv
// constants, field layout and register map of the boot-time pin configuration block
package pin_cfg_pkg;

  localparam int ADDR_W = 20;
  localparam int NUM_PINS = 3;
  localparam int CFG_W = 16;
  localparam int FN_W = 4;
  localparam int NUM_FN = 16;

  // printed register offsets are word indices; byte address is four times the index
  localparam logic [15:0] PIN3_IDX = 16'h781c;
  localparam logic [15:0] PIN4_IDX = 16'h781d;
  localparam logic [15:0] PIN5_IDX = 16'h781e;
  localparam logic [NUM_PINS-1:0][15:0] PIN_IDX = {PIN5_IDX, PIN4_IDX, PIN3_IDX};

  // block-local registers
  localparam logic [ADDR_W-1:0] INT_STATUS_ADDR = 20'h0_0000;
  localparam logic [ADDR_W-1:0] INT_MASK_ADDR = 20'h0_0004;
  localparam logic [ADDR_W-1:0] OUT_DATA_ADDR = 20'h0_0008;
  localparam logic [ADDR_W-1:0] IN_LEVEL_ADDR = 20'h0_000c;

  // per-pin field positions
  localparam int DIR_BIT = 15;
  localparam int PULL_HI = 14;
  localparam int PULL_LO = 13;
  localparam int INT_MODE_BIT = 12;
  localparam int SUPPLY_BIT = 11;
  localparam int POL_BIT = 10;
  localparam int OD_BIT = 9;
  localparam int ENA_BIT = 8;
  localparam int FN_HI = 7;
  localparam int FN_LO = 4;
  localparam int FREQ_HI = 3;
  localparam int FREQ_LO = 1;
  localparam int LED1_HI = 3;
  localparam int LED1_LO = 2;
  localparam int LED2_HI = 1;
  localparam int LED2_LO = 0;
  localparam int ILIM_HI = 3;
  localparam int ILIM_LO = 1;

  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_DOWN = 2'h1;
  localparam logic [1:0] PULL_UP = 2'h2;

  localparam logic [FN_W-1:0] IN_GP_LONG = 4'h0;
  localparam logic [FN_W-1:0] IN_GP = 4'h1;
  localparam logic [FN_W-1:0] IN_SLEEP_WAKE_LONG = 4'h4;
  localparam logic [FN_W-1:0] IN_HW_CTRL1_LONG = 4'he;
  localparam logic [FN_W-1:0] IN_HW_CTRL2_LONG = 4'hf;
  localparam logic [FN_W-1:0] OUT_GP = 4'h0;
  localparam logic [FN_W-1:0] OUT_RSVD_LO = 4'h5;
  localparam logic [FN_W-1:0] OUT_RSVD_HI = 4'h7;

  // reset values: input, pull-down, single edge, active high, push-pull, tri-stated
  localparam logic [15:0] PIN3_RST = 16'ha400;
  localparam logic [15:0] PIN4_RST = 16'ha40f;
  localparam logic [15:0] PIN5_RST = 16'ha404;
  localparam logic [NUM_PINS-1:0][15:0] PIN_RST = {PIN5_RST, PIN4_RST, PIN3_RST};
  // bit 0 of pin3 and pin5 words is reserved and reads zero
  localparam logic [NUM_PINS-1:0][15:0] PIN_WMASK = {16'hfffe, 16'hffff, 16'hfffe};

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int DEBOUNCE_CYCLES = 16;

endpackage

// ### logic/pin_unit.sv
// one configurable pin: input conditioning, edge detection, function routing and pad drive
`timescale 1ns/1ns
module pin_unit
  import pin_cfg_pkg::*;
#(
  parameter int DB_CYCLES = DEBOUNCE_CYCLES
) (
  input wire logic aclk, // block clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [CFG_W-1:0] cfg, // configuration word of this pin
  input wire logic pin_in, // pad level as seen by the input buffer
  input wire logic out_value, // general output value from software
  input wire logic [NUM_FN-1:0] out_sources, // internal status signals per output code
  output logic pin_out, // pad output value
  output logic pin_oe, // pad output enable, high while driving
  output logic pull_up_en, // pull-up resistor enable
  output logic pull_down_en, // pull-down resistor enable
  output logic active_level, // conditioned level after polarity
  output logic edge_event, // one-cycle pulse on an interrupting edge
  output logic [NUM_FN-1:0] requests // input function requests, one-hot by code
);

  localparam int DB_W = $clog2(DB_CYCLES + 1);

  logic sample;
  logic stable;
  logic prev_stable;
  logic [DB_W-1:0] db_count;
  logic is_input;
  logic active_now;
  logic active_prev;
  logic edge_cond;
  logic src;
  logic drive;
  logic [FN_W-1:0] fn;

  function automatic logic long_debounce(input logic [FN_W-1:0] code);
    return code == IN_GP_LONG || code == IN_SLEEP_WAKE_LONG ||
           code == IN_HW_CTRL1_LONG || code == IN_HW_CTRL2_LONG;
  endfunction

  assign fn = cfg[FN_HI:FN_LO];
  assign is_input = cfg[DIR_BIT] & cfg[ENA_BIT];
  assign active_now = cfg[POL_BIT] ? stable : ~stable;
  assign active_prev = cfg[POL_BIT] ? prev_stable : ~prev_stable;
  // mode 0 follows the active edge, so polarity picks rising or falling
  assign edge_cond = cfg[INT_MODE_BIT] ? (stable != prev_stable)
                                       : (active_now & ~active_prev);
  // reserved output codes drive inactive
  assign src = (fn == OUT_GP) ? out_value :
               (fn >= OUT_RSVD_LO && fn <= OUT_RSVD_HI) ? 1'b0 : out_sources[fn];
  assign drive = cfg[POL_BIT] ? src : ~src;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample <= 1'b0;
      prev_stable <= 1'b0;
    end else begin
      sample <= pin_in;
      prev_stable <= stable;
    end
  end

  // long debounce: a new level must hold for DB_CYCLES samples
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stable <= 1'b0;
      db_count <= '0;
    end else if (!long_debounce(fn) || !cfg[DIR_BIT]) begin
      stable <= sample;
      db_count <= '0;
    end else if (sample == stable) begin
      db_count <= '0;
    end else if (db_count == DB_W'(DB_CYCLES - 1)) begin
      stable <= sample;
      db_count <= '0;
    end else begin
      db_count <= db_count + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      edge_event <= 1'b0;
      active_level <= 1'b0;
      requests <= '0;
    end else begin
      edge_event <= is_input & edge_cond;
      active_level <= active_now;
      requests <= is_input ? (NUM_FN'(1) << fn) & {NUM_FN{active_now}} : '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
      pull_up_en <= 1'b0;
      pull_down_en <= 1'b1;
    end else begin
      pin_out <= cfg[OD_BIT] ? 1'b0 : drive;
      pin_oe <= cfg[ENA_BIT] & ~cfg[DIR_BIT] & (cfg[OD_BIT] ? ~drive : 1'b1);
      pull_up_en <= cfg[PULL_HI:PULL_LO] == PULL_UP;
      pull_down_en <= cfg[PULL_HI:PULL_LO] == PULL_DOWN;
    end
  end

endmodule // pin_unit

// ### logic/boot_config_gpio_pins.sv
// start-up configuration of three general-purpose pins with an AXI4-Lite register slave
// How it works
// - pull field: 00 none, 01 pull-down, 10 pull-up, 11 reserved; pull-down default.
// - edge mode 0: interrupt on rising edge if active high, falling if active low.
// - edge mode 1: interrupt on both edges whatever the polarity.
// - polarity 0 means active low, 1 active high; active high after reset.
// - driver bit 0 selects push-pull output, 1 open-drain; push-pull after reset.
// - enable bit 0 keeps the pin tri-stated, 1 lets it work; tri-stated after reset.
// - input code 0 is general input with long debounce, 1 without; field resets 0000.
// - input codes 2 to 7 are power, sleep/wake, sleep, power-on and watchdog requests.
// - input codes 8 to 15 are scaling inputs, hardware enables and hardware controls.
// - output codes 0 to 4: general value, slow clock, ON, SLEEP, state change.
// - output codes 8 to 13: scaling done, external enables, supply and power good.
// - output code 14 is the external power clock, 15 the auxiliary reset.
// - three-bit synthesiser frequency select from 2.048 to 24.576 MHz; default 000.
// - first indicator source: off, power state, charger or manual; default manual.
// - second indicator source: off, power state, charger or manual; default manual.
`timescale 1ns/1ns
module boot_config_gpio_pins
  import pin_cfg_pkg::*;
#(
  parameter int DB_CYCLES = DEBOUNCE_CYCLES
) (
  input wire logic aclk, // 25 MHz block clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [ADDR_W-1:0] awaddr, // write address
  input wire logic [2:0] awprot, // write protection, ignored
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [ADDR_W-1:0] araddr, // read address
  input wire logic [2:0] arprot, // read protection, ignored
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire logic [NUM_PINS-1:0] pin_in, // pad input levels, pins 3..5
  output logic [NUM_PINS-1:0] pin_out, // pad output values
  output logic [NUM_PINS-1:0] pin_oe, // pad output enables
  output logic [NUM_PINS-1:0] pull_up_en, // pull-up enables
  output logic [NUM_PINS-1:0] pull_down_en, // pull-down enables
  output logic [NUM_PINS-1:0] pin_supply_select, // pad supply domain per pin
  input wire logic [NUM_FN-1:0] out_sources, // internal status signals by output code
  output logic [NUM_FN-1:0] input_requests, // requests by input code, any pin
  output logic [2:0] synth_auto_frequency, // synthesiser automatic frequency code
  output logic [1:0] first_indicator_source, // first indicator source select
  output logic [1:0] second_indicator_source, // second indicator source select
  output logic [2:0] usb_current_limit, // supply current limit code
  output logic irq // level interrupt, high while an unmasked status bit is set
);

  //////////////////////////////////////////////////////////////////////////////

  logic [NUM_PINS-1:0][CFG_W-1:0] pin_cfg;
  logic [NUM_PINS-1:0] int_status;
  logic [NUM_PINS-1:0] int_mask;
  logic [NUM_PINS-1:0] out_data;
  logic [NUM_PINS-1:0] active_level;
  logic [NUM_PINS-1:0] edge_event;
  logic [NUM_PINS-1:0][NUM_FN-1:0] pin_requests;
  logic [NUM_FN-1:0] next_requests;

  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic do_write;
  logic wr_mapped;
  logic [NUM_PINS-1:0] status_clear;
  logic [31:0] next_rdata;
  logic rd_mapped;

  function automatic logic [ADDR_W-1:0] pin_addr(input int idx);
    return {2'b00, PIN_IDX[idx], 2'b00};
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    logic hit;
    hit = addr == INT_STATUS_ADDR || addr == INT_MASK_ADDR ||
          addr == OUT_DATA_ADDR || addr == IN_LEVEL_ADDR;
    for (int i = 0; i < NUM_PINS; i++) begin
      hit = hit | (addr == pin_addr(i));
    end
    return hit;
  endfunction

  // byte lanes above the low halfword carry nothing
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb, input logic [15:0] wmask);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res & wmask;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // write channel: address and data are taken in either order, response after both

  assign do_write = ~awready & ~wready & ~bvalid;
  assign wr_mapped = is_mapped(aw_addr_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      aw_addr_q <= '0;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      aw_addr_q <= awaddr;
    end else if (bvalid && bready) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready <= 1'b1;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end else if (bvalid && bready) begin
      wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // configuration words; the whole word is stored except reserved bit 0 of pins 3 and 5, fields fan out below

  for (genvar i = 0; i < NUM_PINS; i++) begin : g_cfg
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pin_cfg[i] <= PIN_RST[i];
      end else if (do_write && aw_addr_q == pin_addr(i)) begin
        pin_cfg[i] <= merge16(pin_cfg[i], w_data_q, w_strb_q, PIN_WMASK[i]);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_mask <= '0;
      out_data <= '0;
    end else if (do_write && aw_addr_q == INT_MASK_ADDR && w_strb_q[0]) begin
      int_mask <= w_data_q[NUM_PINS-1:0];
    end else if (do_write && aw_addr_q == OUT_DATA_ADDR && w_strb_q[0]) begin
      out_data <= w_data_q[NUM_PINS-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pins

  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    pin_unit #(
      .DB_CYCLES(DB_CYCLES)
    ) u_pin (
      .aclk(aclk),
      .aresetn(aresetn),
      .cfg(pin_cfg[i]),
      .pin_in(pin_in[i]),
      .out_value(out_data[i]),
      .out_sources(out_sources),
      .pin_out(pin_out[i]),
      .pin_oe(pin_oe[i]),
      .pull_up_en(pull_up_en[i]),
      .pull_down_en(pull_down_en[i]),
      .active_level(active_level[i]),
      .edge_event(edge_event[i]),
      .requests(pin_requests[i])
    );
  end

  always_comb begin
    next_requests = '0;
    for (int i = 0; i < NUM_PINS; i++) begin
      next_requests = next_requests | pin_requests[i];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      input_requests <= '0;
    end else begin
      input_requests <= next_requests;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_supply_select <= '0;
      synth_auto_frequency <= '0;
      first_indicator_source <= 2'h3;
      second_indicator_source <= 2'h3;
      usb_current_limit <= 3'h2;
    end else begin
      for (int i = 0; i < NUM_PINS; i++) begin
        pin_supply_select[i] <= pin_cfg[i][SUPPLY_BIT];
      end
      synth_auto_frequency <= pin_cfg[0][FREQ_HI:FREQ_LO];
      first_indicator_source <= pin_cfg[1][LED1_HI:LED1_LO];
      second_indicator_source <= pin_cfg[1][LED2_HI:LED2_LO];
      usb_current_limit <= pin_cfg[2][ILIM_HI:ILIM_LO];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupts: a fresh edge wins over a same-cycle clear

  always_comb begin
    status_clear = '0;
    if (do_write && aw_addr_q == INT_STATUS_ADDR && w_strb_q[0]) begin
      status_clear = w_data_q[NUM_PINS-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_status <= '0;
    end else begin
      int_status <= (int_status & ~status_clear) | edge_event;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_status & int_mask);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read channel: data one cycle after the address is taken

  assign rd_mapped = is_mapped(araddr);

  always_comb begin
    next_rdata = '0;
    if (araddr == INT_STATUS_ADDR) begin
      next_rdata[NUM_PINS-1:0] = int_status;
    end else if (araddr == INT_MASK_ADDR) begin
      next_rdata[NUM_PINS-1:0] = int_mask;
    end else if (araddr == OUT_DATA_ADDR) begin
      next_rdata[NUM_PINS-1:0] = out_data;
    end else if (araddr == IN_LEVEL_ADDR) begin
      next_rdata[NUM_PINS-1:0] = active_level;
    end else begin
      for (int i = 0; i < NUM_PINS; i++) begin
        if (araddr == pin_addr(i)) begin
          next_rdata[CFG_W-1:0] = pin_cfg[i];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= next_rdata;
      rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
    end
  end

endmodule // boot_config_gpio_pins

// ### test/pad_partner.sv
// pad-side model: external signals that drive or sense the three pins
`timescale 1ns/1ns
module pad_partner
  import pin_cfg_pkg::*;
(
  input wire logic aclk, // clock for the floating-pin pattern
  input wire logic [NUM_PINS-1:0] pin_out, // block drive value
  input wire logic [NUM_PINS-1:0] pin_oe, // block drive enable
  input wire logic [NUM_PINS-1:0] pull_up_en, // pull-up on
  input wire logic [NUM_PINS-1:0] pull_down_en, // pull-down on
  input wire logic [NUM_PINS-1:0] ext_en, // external source drives the pin
  input wire logic [NUM_PINS-1:0] ext_lvl, // external source level
  output logic [NUM_PINS-1:0] pad // resolved wire level
);
  logic idle_pat = 1'b0;

  // a pin nobody drives or pulls wanders, so no stale level is seen
  always_ff @(posedge aclk) begin
    idle_pat <= !idle_pat;
  end

  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (pin_oe[i]) pad[i] = pin_out[i];
      else if (ext_en[i]) pad[i] = ext_lvl[i];
      else if (pull_up_en[i]) pad[i] = 1'b1;
      else if (pull_down_en[i]) pad[i] = 1'b0;
      else pad[i] = idle_pat;
    end
  end
endmodule // pad_partner

// ### test/pin_cfg_chk.sv
// port assertions for the boot-time pin configuration block
`timescale 1ns/1ns
module pin_cfg_chk
  import pin_cfg_pkg::*;
(
  input wire logic aclk, // clock
  input wire logic aresetn, // reset, active low
  input wire logic awvalid, // write address valid
  input wire logic awready, // write address ready
  input wire logic wvalid, // write data valid
  input wire logic wready, // write data ready
  input wire logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic arvalid, // read address valid
  input wire logic arready, // read address ready
  input wire logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire logic [NUM_PINS-1:0] pin_oe, // pad enables
  input wire logic [NUM_PINS-1:0] pull_up_en, // pull-ups
  input wire logic [NUM_PINS-1:0] pull_down_en, // pull-downs
  input wire logic [2:0] synth_auto_frequency, // synthesiser code
  input wire logic [1:0] first_indicator_source, // first indicator
  input wire logic [1:0] second_indicator_source, // second indicator
  input wire logic irq // interrupt
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
////////////////////////////////////////////////////////////////////////////////
  chk_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response not on time");
  chk_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read data not on time");
  chk_aw_blocked: assert property (bvalid |-> !awready && !wready)
    else $error("write channel open during response");
  chk_ar_blocked: assert property (rvalid |-> !arready)
    else $error("read channel open during response");
  chk_pull_excl: assert property ((pull_up_en & pull_down_en) == 3'h0)
    else $error("both pulls on");
  chk_pull_reset: assert property ($rose(aresetn) |-> pull_down_en == 3'h7 && pull_up_en == 3'h0)
    else $error("pull default wrong");
  chk_oe_reset: assert property ($rose(aresetn) |-> pin_oe == 3'h0)
    else $error("pin driven after reset");
  chk_led_reset: assert property ($rose(aresetn) |-> first_indicator_source == 2'h3 && second_indicator_source == 2'h3)
    else $error("indicator default wrong");
  chk_synth_reset: assert property ($rose(aresetn) |-> synth_auto_frequency == 3'h0)
    else $error("synthesiser default wrong");
  chk_irq_quiet: assert property ($rose(aresetn) |-> !irq [*2])
    else $error("interrupt after reset");
////////////////////////////////////////////////////////////////////////////////
  cover property (bvalid && bready);
  cover property (rvalid && rready);
  cover property ($rose(irq));
endmodule // pin_cfg_chk

bind boot_config_gpio_pins pin_cfg_chk chk_u (.aclk, .aresetn, .awvalid, .awready, .wvalid,
  .wready, .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .pin_oe, .pull_up_en,
  .pull_down_en, .synth_auto_frequency, .first_indicator_source, .second_indicator_source, .irq);

// ### test/testbench.sv
// self-checking bench: register bus, pad functions and pin interrupts
`timescale 1ns/1ns
module testbench
  import pin_cfg_pkg::*;
;
  localparam logic [15:0] RST_WORD [3] = '{16'ha400, 16'ha40f, 16'ha404};
  localparam logic [15:0] EDGE_CFG [3] = '{16'ha51f, 16'ha11f, 16'hb51f};
  logic aclk, awready, wready, bvalid, arready, rvalid, irq;
  logic aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, od_bit = 1'b0;
  logic [ADDR_W-1:0] awaddr = 20'h0_0000, araddr = 20'h0_0000;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp, led1, led2;
  logic [2:0] pin_in, pin_out, pin_oe, pu, pd, freq, ext_en = 3'h0, ext_lvl = 3'h0;
  logic [15:0] src = 16'h0000, req;
  logic [2:0] ilim, psel;
  logic [33:0] rq[$], bq[$];
  int miscompares = 0, check_count = 0;

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  boot_config_gpio_pins #(.DB_CYCLES(2)) dut_u (.aclk, .aresetn, .awaddr, .awprot(3'h0),
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .pin_in, .pin_out,
    .pin_oe, .pull_up_en(pu), .pull_down_en(pd), .pin_supply_select(psel), .out_sources(src),
    .input_requests(req), .synth_auto_frequency(freq), .first_indicator_source(led1),
    .second_indicator_source(led2), .usb_current_limit(ilim), .irq);
  pad_partner pad_u (.aclk, .pin_out, .pin_oe, .pull_up_en(pu), .pull_down_en(pd), .ext_en,
    .ext_lvl, .pad(pin_in));
////////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  function automatic logic [19:0] pa(input int i);
    return {2'b00, PIN_IDX[i], 2'b00};
  endfunction

  task automatic wr(input logic [19:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    bq.push_back({r, 32'h0});
    // no local limit: only the watchdog ends a wait for the answer
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [19:0] a, input logic [33:0] e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rq.push_back(e);
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask

  // answers are matched to notes in issue order
  always @(posedge aclk) begin
    if (rvalid && rready) cmp({rresp, rdata}, rq.pop_front());
    if (bvalid && bready) cmp({bresp, 32'h0}, bq.pop_front());
  end

  initial begin
    repeat (30000) @(posedge aclk);
    miscompares++;
    results();
  end
////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic v;
    logic [3:0] e4;
    logic [31:0] d;
    void'($urandom(76));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 3; i++) rd(pa(i), 34'(RST_WORD[i]));
    rd(INT_MASK_ADDR, 34'h0);
    rd(20'h0_0100, {RESP_SLVERR, 32'h0});
    wr(20'h0_0100, 32'h1234_5678, RESP_SLVERR);
    $display("test reset done");
    for (int k = 0; k < 8; k++) begin
      wr(pa(0), {16'h0, 12'ha40, k[2:0], 1'b0}, RESP_OKAY);
      repeat (2) @(posedge aclk);
      cmp(34'(freq), 34'(k[2:0]));
    end
    for (int k = 0; k < 4; k++) begin
      wr(pa(1), {16'h0, 12'ha40, k[1:0], ~k[1:0]}, RESP_OKAY);
      repeat (2) @(posedge aclk);
      cmp(34'({led1, led2}), 34'({k[1:0], ~k[1:0]}));
    end
    d = $urandom;
    wr(pa(1), d, RESP_OKAY);
    rd(pa(1), 34'(d[15:0]));
    cmp(34'({ilim, psel}), 34'({3'h2, 1'b0, d[11], 1'b0}));
    $display("test fields done");
    d = $urandom;
    od_bit = d[0];
    wr(OUT_DATA_ADDR, d, RESP_OKAY);
    rd(OUT_DATA_ADDR, 34'(d[2:0]));
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 16; k++) begin
        src <= 16'($urandom);
        wr(pa(0), {17'h0, m[1:0], 2'b00, m != 1, m == 2, m != 3, k[3:0], 4'h0}, RESP_OKAY);
        repeat (2) @(posedge aclk);
        v = (k == 0) ? od_bit : (k >= 5 && k <= 7) ? 1'b0 : src[k];
        v = v ^ (m == 1);
        e4 = {m != 3 && (m != 2 || !v), v && m < 2, m == 2, m == 1};
        cmp(34'({pin_oe[0], pin_out[0] & pin_oe[0], pu[0], pd[0]}), 34'(e4));
      end
    end
    $display("test outputs done");
    ext_en <= 3'b010;
    ext_lvl <= 3'b000;
    wr(INT_MASK_ADDR, 32'h0000_0007, RESP_OKAY);
    for (int k = 0; k < 16; k++) begin
      wr(pa(1), {16'h0, 8'ha5, k[3:0], 4'hf}, RESP_OKAY);
      ext_lvl <= 3'b010;
      repeat (5) @(posedge aclk);
      // with two-sample debounce the long codes lag the plain ones by exactly one edge
      cmp(34'(req), (k inside {0, 4, 14, 15}) ? 34'h0 : 34'(16'h0001 << k));
      repeat (5) @(posedge aclk);
      cmp(34'(req), 34'(16'h0001 << k));
      ext_lvl <= 3'b000;
      repeat (10) @(posedge aclk);
      cmp(34'(req), 34'h0);
    end
    wr(pa(1), 32'h0000_251f, RESP_OKAY);
    ext_lvl <= 3'b010;
    repeat (10) @(posedge aclk);
    cmp(34'(req), 34'h0);
    $display("test requests done");
    for (int j = 0; j < 3; j++) begin
      ext_lvl <= 3'b000;
      wr(pa(1), 32'(EDGE_CFG[j]), RESP_OKAY);
      repeat (10) @(posedge aclk);
      wr(INT_STATUS_ADDR, 32'h0000_0007, RESP_OKAY);
      ext_lvl <= 3'b010;
      repeat (10) @(posedge aclk);
      rd(INT_STATUS_ADDR, (j != 1) ? 34'h2 : 34'h0);
      cmp(34'(irq), 34'(j != 1));
      wr(INT_STATUS_ADDR, 32'h0000_0007, RESP_OKAY);
      ext_lvl <= 3'b000;
      repeat (10) @(posedge aclk);
      rd(INT_STATUS_ADDR, (j != 0) ? 34'h2 : 34'h0);
      cmp(34'(irq), 34'(j != 0));
    end
    wr(INT_MASK_ADDR, 32'h0000_0000, RESP_OKAY);
    repeat (2) @(posedge aclk);
    cmp(34'(irq), 34'h0);
    wr(INT_MASK_ADDR, 32'h0000_0007, RESP_OKAY);
    repeat (2) @(posedge aclk);
    cmp(34'(irq), 34'h1);
    wr(INT_STATUS_ADDR, 32'h0000_0007, RESP_OKAY);
    repeat (2) @(posedge aclk);
    cmp(34'(irq), 34'h0);
    $display("test interrupts done");
    repeat (5) @(posedge aclk);
    results();
  end
endmodule // testbench
